// File: rtl/dmachr_top.sv
// Three-channel transfer control registers with address stepping
`timescale 1ns/1ps
`default_nettype none
module dmachr_top (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] trigger_i,
  input wire logic nmi_i,
  input wire logic xfer_done_i,
  output logic [2:0] xfer_req_o,
  output logic [19:0] xfer_src_o,
  output logic [19:0] xfer_dst_o,
  output logic xfer_src_byte_o,
  output logic xfer_dst_byte_o,
  output logic [1:0] xfer_ch_o,
  output logic [2:0] irq_o
);
  logic [15:0] ctl [3];
  logic [19:0] sa [3];
  logic [19:0] da [3];
  logic [19:0] wsa [3];
  logic [19:0] wda [3];
  logic [15:0] sz [3];
  logic [15:0] wsz [3];
  logic [2:0] busy;
  logic [2:0] trig_s1, trig_s2, trig_d;
  logic nmi_s1, nmi_s2;
  logic [2:0] pend;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have, w_have;
  logic do_write;
  logic [1:0] wch, cur;
  logic [7:0] woff;
  logic wvalid_ch;
  logic [15:0] iv_val;
  logic [2:0] rch;
  logic [7:0] roff;

  // Step amount per element width and step code
  function automatic logic [19:0] step_addr(input logic [19:0] a, input logic [1:0] code,
                                            input logic is_byte);
    logic [19:0] d;
    d = is_byte ? 20'h00001 : 20'h00002;
    unique case (dmachr_pkg::dmachr_step_t'(code))
      dmachr_pkg::DMACHR_STEP_DEC: step_addr = a - d;
      dmachr_pkg::DMACHR_STEP_INC: step_addr = a + d;
      dmachr_pkg::DMACHR_STEP_HOLD0, dmachr_pkg::DMACHR_STEP_HOLD1: step_addr = a;
    endcase
  endfunction

  // Split address into channel index and offset within channel window
  function automatic logic [2:0] dec_addr(input logic [31:0] a, output logic [7:0] off);
    logic [7:0] lo;
    lo = a[7:0];
    off = lo & (dmachr_pkg::CH_STRIDE - 8'h01);
    dec_addr = (a[31:7] != 25'h0) ? 3'd3 : {1'b0, lo[6:5]};
  endfunction

  // Repeated modes keep the channel enabled
  function automatic logic mode_repeat(input logic [15:0] c);
    mode_repeat = c[dmachr_pkg::B_MODE_LO + 2];
  endfunction

  function automatic logic [1:0] mode_kind(input logic [15:0] c);
    mode_kind = c[dmachr_pkg::B_MODE_LO + 1] ? 2'b10 : {1'b0, c[dmachr_pkg::B_MODE_LO]};
  endfunction

  // Pin sync: trigger and NMI come from other logic domains
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trig_s1 <= 3'h0;
      trig_s2 <= 3'h0;
      trig_d <= 3'h0;
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
    end else begin
      trig_s1 <= trigger_i;
      trig_s2 <= trig_s1;
      trig_d <= trig_s2;
      nmi_s1 <= nmi_i;
      nmi_s2 <= nmi_s1;
    end
  end

  // Write channel capture: address and data arrive in any order
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have <= 1'b0;
      end
    end
  end

  assign do_write = aw_have && w_have && !s_axi_bvalid;
  always_comb begin
    logic [2:0] c;
    c = dec_addr(awaddr_q, woff);
    wch = c[1:0];
    wvalid_ch = (c < 3'd3) && (woff <= dmachr_pkg::OFF_SZ) && (woff[1:0] == 2'b00);
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dmachr_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wvalid_ch ? dmachr_pkg::RESP_OKAY : dmachr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Pending flags ranked for the vector, channel 0 highest
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pend[i] = ctl[i][dmachr_pkg::B_IFG];
    end
    if (pend[0]) iv_val = 16'h0002;
    else if (pend[1]) iv_val = 16'h0004;
    else if (pend[2]) iv_val = 16'h0006;
    else iv_val = 16'h0000;
  end

  // Channel state: registers, working copies, counters
  for (genvar g = 0; g < 3; g++) begin : g_ch
    logic trig_hit;
    logic go;
    logic done;
    logic wr_ctl, wr_salo, wr_sahi, wr_dalo, wr_dahi, wr_sz;
    assign wr_ctl = do_write && wvalid_ch && wch == g && woff == dmachr_pkg::OFF_CTL;
    assign wr_salo = do_write && wvalid_ch && wch == g && woff == dmachr_pkg::OFF_SA_LO;
    assign wr_sahi = do_write && wvalid_ch && wch == g && woff == dmachr_pkg::OFF_SA_HI;
    assign wr_dalo = do_write && wvalid_ch && wch == g && woff == dmachr_pkg::OFF_DA_LO;
    assign wr_dahi = do_write && wvalid_ch && wch == g && woff == dmachr_pkg::OFF_DA_HI;
    assign wr_sz = do_write && wvalid_ch && wch == g && woff == dmachr_pkg::OFF_SZ;
    // Level sensing holds request while high, edge only on rise
    assign trig_hit = ctl[g][dmachr_pkg::B_LEVEL] ? trig_s2[g] : (trig_s2[g] && !trig_d[g]);
    // Enabled and nonzero size required; size zero means off
    assign go = ctl[g][dmachr_pkg::B_EN] && (sz[g] != 16'h0) && !busy[g] &&
                (trig_hit || ctl[g][dmachr_pkg::B_START]);
    assign done = busy[g] && xfer_done_i && cur == g;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        ctl[g] <= dmachr_pkg::CTL_RESET;
        busy[g] <= 1'b0;
      end else begin
        if (wr_ctl) begin
          ctl[g] <= wdata_q[15:0] & dmachr_pkg::CTL_WMASK;
        end else begin
          ctl[g][dmachr_pkg::B_START] <= 1'b0;
        end
        if (go) busy[g] <= 1'b1;
        else if (done && (mode_kind(ctl[g]) == 2'b00 || wsz[g] == 16'h0001)) busy[g] <= 1'b0;
        if (busy[g] && nmi_s2) begin
          busy[g] <= 1'b0;
          ctl[g][dmachr_pkg::B_EN] <= 1'b0;
          ctl[g][dmachr_pkg::B_ABORT] <= 1'b1;
        end else if (done && wsz[g] == 16'h0001) begin
          // Block end: flag wins over a same-cycle clear
          ctl[g][dmachr_pkg::B_IFG] <= 1'b1;
          if (!mode_repeat(ctl[g])) ctl[g][dmachr_pkg::B_EN] <= 1'b0;
        end
      end
    end

    // Software copies stay fixed; only working copies step
    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        sa[g] <= 20'h0;
        da[g] <= 20'h0;
        sz[g] <= 16'h0;
      end else begin
        if (wr_salo) sa[g] <= {4'h0, wdata_q[15:0]};
        else if (wr_sahi) sa[g][19:16] <= wdata_q[3:0] & dmachr_pkg::UPPER_MASK;
        if (wr_dalo) da[g] <= {4'h0, wdata_q[15:0]};
        else if (wr_dahi) da[g][19:16] <= wdata_q[3:0] & dmachr_pkg::UPPER_MASK;
        if (wr_sz) sz[g] <= wdata_q[15:0];
      end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        wsa[g] <= 20'h0;
        wda[g] <= 20'h0;
        wsz[g] <= 16'h0;
      end else begin
        if (wr_salo || wr_sahi || wr_ctl) wsa[g] <= wr_salo ? {4'h0, wdata_q[15:0]} : sa[g];
        else if (done) begin
          // Block and burst reload working source at block end
          if (mode_kind(ctl[g]) != 2'b00 && wsz[g] == 16'h0001) wsa[g] <= sa[g];
          else wsa[g] <= step_addr(wsa[g], ctl[g][9:8], ctl[g][dmachr_pkg::B_SBYTE]);
        end
        if (wr_dalo || wr_dahi || wr_ctl) wda[g] <= wr_dalo ? {4'h0, wdata_q[15:0]} : da[g];
        else if (done) begin
          if (mode_kind(ctl[g]) != 2'b00 && wsz[g] == 16'h0001) wda[g] <= da[g];
          else wda[g] <= step_addr(wda[g], ctl[g][11:10], ctl[g][dmachr_pkg::B_DBYTE]);
        end
        if (wr_sz) wsz[g] <= wdata_q[15:0];
        else if (done) wsz[g] <= (wsz[g] == 16'h0001) ? sz[g] : wsz[g] - 16'h0001;
      end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) irq_o[g] <= 1'b0;
      else irq_o[g] <= ctl[g][dmachr_pkg::B_IFG] && ctl[g][dmachr_pkg::B_IE];
    end

    AST_IRQ_GATE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      irq_o[g] |-> $past(ctl[g][dmachr_pkg::B_IFG] && ctl[g][dmachr_pkg::B_IE]))
      else $error("irq without flag and enable");
    AST_START_CLEARS: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      ctl[g][dmachr_pkg::B_START] && !wr_ctl |=> !ctl[g][dmachr_pkg::B_START])
      else $error("start bit did not self clear");
    AST_SZ_ZERO_IDLE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      sz[g] == 16'h0 |-> !go)
      else $error("zero size started a transfer");
    AST_DISABLED_IDLE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !ctl[g][dmachr_pkg::B_EN] |-> !go)
      else $error("disabled channel started");
    AST_SA_FIXED: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      done && !wr_salo && !wr_sahi |=> $stable(sa[g]))
      else $error("source register moved");
    AST_DA_FIXED: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      done && !wr_dalo && !wr_dahi |=> $stable(da[g]))
      else $error("destination register moved");
    AST_SRC_INC: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      done && !wr_ctl && !wr_salo && !wr_sahi && wsz[g] != 16'h0001 &&
      ctl[g][9:8] == 2'b11 && !ctl[g][dmachr_pkg::B_SBYTE]
      |=> wsa[g] == $past(wsa[g]) + 20'h00002)
      else $error("word source not stepped by two");
    AST_DST_DEC: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      done && !wr_ctl && !wr_dalo && !wr_dahi && wsz[g] != 16'h0001 &&
      ctl[g][11:10] == 2'b10 && ctl[g][dmachr_pkg::B_DBYTE]
      |=> wda[g] == $past(wda[g]) - 20'h00001)
      else $error("byte destination not stepped down by one");
    AST_SZ_RELOAD: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      done && !wr_sz && wsz[g] == 16'h0001 |=> wsz[g] == sz[g])
      else $error("size not reloaded");
    AST_ABORT_SET: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      busy[g] && nmi_s2 |=> ctl[g][dmachr_pkg::B_ABORT] && !busy[g])
      else $error("abort not flagged");
  end

  // One transfer at a time, lowest channel first
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur <= 2'd0;
      xfer_req_o <= 3'h0;
      xfer_src_o <= 20'h0;
      xfer_dst_o <= 20'h0;
      xfer_src_byte_o <= 1'b0;
      xfer_dst_byte_o <= 1'b0;
      xfer_ch_o <= 2'd0;
    end else begin
      xfer_req_o <= busy & ~(xfer_done_i ? (3'b001 << cur) : 3'b000);
      if (busy[0]) cur <= 2'd0;
      else if (busy[1]) cur <= 2'd1;
      else cur <= 2'd2;
      xfer_ch_o <= cur;
      xfer_src_o <= wsa[cur];
      xfer_dst_o <= wda[cur];
      xfer_src_byte_o <= ctl[cur][dmachr_pkg::B_SBYTE];
      xfer_dst_byte_o <= ctl[cur][dmachr_pkg::B_DBYTE];
    end
  end

  // Read channel; upper words expose only bits 3-0
  always_comb rch = dec_addr(s_axi_araddr, roff);
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= dmachr_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= dmachr_pkg::RESP_OKAY;
        s_axi_rdata <= 32'h0;
        if (s_axi_araddr[31:0] == {24'h0, dmachr_pkg::OFF_IV}) begin
          s_axi_rdata <= {16'h0, iv_val};
        end else if (rch == 3'd3 || roff[1:0] != 2'b00) begin
          s_axi_rresp <= dmachr_pkg::RESP_SLVERR;
        end else begin
          unique case (roff)
            dmachr_pkg::OFF_CTL: s_axi_rdata <= {16'h0, ctl[rch[1:0]]};
            dmachr_pkg::OFF_SA_LO: s_axi_rdata <= {16'h0, sa[rch[1:0]][15:0]};
            dmachr_pkg::OFF_SA_HI: s_axi_rdata <= {28'h0, sa[rch[1:0]][19:16]};
            dmachr_pkg::OFF_DA_LO: s_axi_rdata <= {16'h0, da[rch[1:0]][15:0]};
            dmachr_pkg::OFF_DA_HI: s_axi_rdata <= {28'h0, da[rch[1:0]][19:16]};
            dmachr_pkg::OFF_SZ: s_axi_rdata <= {16'h0, wsz[rch[1:0]]};
            dmachr_pkg::OFF_WSA: s_axi_rdata <= {12'h0, wsa[rch[1:0]]};
            dmachr_pkg::OFF_WDA: s_axi_rdata <= {12'h0, wda[rch[1:0]]};
            default: s_axi_rresp <= dmachr_pkg::RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: shared/dmachr_pkg.sv
// Shared constants for the three-channel transfer register block
package dmachr_pkg;
  localparam int NUM_CH = 3;
  // Per-channel register window: base = ch * CH_STRIDE
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] OFF_CTL = 8'h00;
  localparam logic [7:0] OFF_SA_LO = 8'h04;
  localparam logic [7:0] OFF_SA_HI = 8'h08;
  localparam logic [7:0] OFF_DA_LO = 8'h0c;
  localparam logic [7:0] OFF_DA_HI = 8'h10;
  localparam logic [7:0] OFF_SZ = 8'h14;
  localparam logic [7:0] OFF_WSA = 8'h18;
  localparam logic [7:0] OFF_WDA = 8'h1c;
  localparam logic [7:0] OFF_IV = 8'h60;
  localparam logic [7:0] OFF_WSZ = 8'h64;
  // Control field positions
  localparam int B_MODE_LO = 12;
  localparam int B_DSTEP_LO = 10;
  localparam int B_SSTEP_LO = 8;
  localparam int B_DBYTE = 7;
  localparam int B_SBYTE = 6;
  localparam int B_LEVEL = 5;
  localparam int B_EN = 4;
  localparam int B_IFG = 3;
  localparam int B_IE = 2;
  localparam int B_ABORT = 1;
  localparam int B_START = 0;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] CTL_WMASK = 16'h7fff;
  localparam logic [3:0] UPPER_MASK = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    DMACHR_STEP_HOLD0 = 2'b00,
    DMACHR_STEP_HOLD1 = 2'b01,
    DMACHR_STEP_DEC = 2'b10,
    DMACHR_STEP_INC = 2'b11
  } dmachr_step_t;
  typedef enum logic [1:0] {
    DMACHR_MODE_SINGLE = 2'b00,
    DMACHR_MODE_BLOCK = 2'b01,
    DMACHR_MODE_BURST = 2'b10
  } dmachr_mode_t;
endpackage

// File: verif/dmachr_mover.sv
// Behavioural data mover answering element requests after a set delay
`timescale 1ns/1ps
`default_nettype none
module dmachr_mover (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [2:0] req_i,
  input wire logic [19:0] src_i,
  input wire logic [19:0] dst_i,
  input wire logic [3:0] lat_i,
  output logic done_o,
  output logic [19:0] src_o,
  output logic [19:0] dst_o,
  output logic [31:0] moves_o
);
  logic [3:0] cnt;
  // Count restarts after each pulse, so the stale request is never answered twice
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 4'h0;
      done_o <= 1'b0;
      src_o <= 20'h00000;
      dst_o <= 20'h00000;
      moves_o <= 32'h0;
    end else begin
      done_o <= 1'b0;
      if (req_i == 3'h0 || done_o) begin
        cnt <= 4'h0;
      end else if (cnt == lat_i) begin
        cnt <= 4'h0;
        done_o <= 1'b1;
        src_o <= src_i;
        dst_o <= dst_i;
        moves_o <= moves_o + 32'h1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/test_dmachr_top.sv
// Register-level test of the three-channel transfer control block
`timescale 1ns/1ps
`default_nettype none
module test_dmachr_top;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, done;
  logic nmi = 1'b0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, moves;
  logic [2:0] trig = 3'h0, req, irq;
  logic [19:0] src, dst, seen_src, seen_dst;
  logic [3:0] lat = 4'h2;
  logic sb, db;
  logic [1:0] xch;
  int mismatches = 0;
  int checks = 0;

  always #20 mclk_i = ~mclk_i;

  dmachr_top uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trigger_i(trig), .nmi_i(nmi), .xfer_done_i(done),
    .xfer_req_o(req), .xfer_src_o(src), .xfer_dst_o(dst), .xfer_src_byte_o(sb),
    .xfer_dst_byte_o(db), .xfer_ch_o(xch), .irq_o(irq));

  dmachr_mover mover (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req), .src_i(src),
    .dst_i(dst), .lat_i(lat), .done_o(done), .src_o(seen_src), .dst_o(seen_dst),
    .moves_o(moves));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] ad(input int ch, input logic [7:0] off);
    return {24'h0, 8'(ch) * dmachr_pkg::CH_STRIDE + off};
  endfunction

  // Readys are sampled before the edge lands, so release follows the real handshake
  task automatic wr(input int ch, input logic [7:0] off, input logic [31:0] d,
                    input logic [1:0] er = dmachr_pkg::RESP_OKAY);
    awaddr <= ad(ch, off);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    // Idle edge so the next call never raises bready in the same step
    bready <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input int ch, input logic [7:0] off, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= ad(ch, off);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rc(input int ch, input logic [7:0] off, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(ch, off, d, r);
    chk("rresp", {30'h0, r}, 32'h0);
    chk("rdata", d, exp);
  endtask

  // Extra settle cycles let a spurious second move show up
  task automatic mv(input logic [31:0] k);
    int n;
    n = 0;
    while (moves !== k && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
    repeat (12) @(posedge mclk_i);
    chk("moves", moves, k);
  endtask

  initial begin
    logic [31:0] m, es, ed, d;
    logic [1:0] cc, r;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rc(0, dmachr_pkg::OFF_CTL, 32'h0);
    wr(0, dmachr_pkg::OFF_SA_HI, 32'hffff_ffff);
    rc(0, dmachr_pkg::OFF_SA_HI, 32'hf);
    wr(0, dmachr_pkg::OFF_SA_LO, 32'h100);
    rc(0, dmachr_pkg::OFF_SA_HI, 32'h0);
    wr(0, dmachr_pkg::OFF_DA_LO, 32'h200);
    wr(0, dmachr_pkg::OFF_SZ, 32'd100);
    for (int i = 0; i < 4; i++) begin
      cc = 2'(i);
      wr(0, dmachr_pkg::OFF_CTL, {20'h0, cc, cc, ~cc[0], cc[0], 6'h11});
      mv(32'(i + 1));
      es = (cc == 2'b11) ? 32'h101 : (cc == 2'b10) ? 32'hfe : 32'h100;
      ed = (cc == 2'b11) ? 32'h202 : (cc == 2'b10) ? 32'h1ff : 32'h200;
      rc(0, dmachr_pkg::OFF_WSA, es);
      rc(0, dmachr_pkg::OFF_WDA, ed);
      chk("mover src", {12'h0, seen_src}, 32'h100);
      chk("mover dst", {12'h0, seen_dst}, 32'h200);
    end
    rc(0, dmachr_pkg::OFF_SA_LO, 32'h100);
    rc(0, dmachr_pkg::OFF_DA_LO, 32'h200);
    rc(0, dmachr_pkg::OFF_SZ, 32'd96);
    rc(0, dmachr_pkg::OFF_CTL, 32'h0f50);
    wr(0, dmachr_pkg::OFF_SZ, 32'h2);
    wr(0, dmachr_pkg::OFF_CTL, 32'h1315);
    mv(32'd6);
    rc(0, dmachr_pkg::OFF_CTL, 32'h130c);
    rc(0, dmachr_pkg::OFF_SZ, 32'h2);
    chk("irq", {29'h0, irq}, 32'h1);
    wr(1, dmachr_pkg::OFF_SZ, 32'h0);
    wr(1, dmachr_pkg::OFF_CTL, 32'h1015);
    mv(32'd6);
    wr(1, dmachr_pkg::OFF_SZ, 32'h1);
    wr(1, dmachr_pkg::OFF_CTL, 32'h1015);
    mv(32'd7);
    chk("irq", {29'h0, irq}, 32'h3);
    rc(0, dmachr_pkg::OFF_IV, 32'h2);
    wr(0, dmachr_pkg::OFF_CTL, 32'h0001);
    mv(32'd7);
    rc(0, dmachr_pkg::OFF_IV, 32'h4);
    wr(1, dmachr_pkg::OFF_CTL, 32'h0);
    rc(0, dmachr_pkg::OFF_IV, 32'h0);
    chk("irq", {29'h0, irq}, 32'h0);
    wr(0, dmachr_pkg::OFF_IV, 32'h6, dmachr_pkg::RESP_SLVERR);
    rd(0, 8'h80, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, dmachr_pkg::RESP_SLVERR});
    // Slow mover keeps the channel busy when the abort arrives
    lat <= 4'h6;
    wr(2, dmachr_pkg::OFF_SZ, 32'h5);
    wr(2, dmachr_pkg::OFF_CTL, 32'h4010);
    trig <= 3'h4;
    mv(32'd8);
    wr(2, dmachr_pkg::OFF_CTL, 32'h40f0);
    m = moves;
    repeat (60) @(posedge mclk_i);
    chk("level moves", 32'(moves >= m + 2), 32'h1);
    chk("byte flags", {28'h0, xch, sb, db}, 32'hb);
    nmi <= 1'b1;
    repeat (12) @(posedge mclk_i);
    m = moves;
    repeat (40) @(posedge mclk_i);
    chk("moves after abort", moves, m);
    nmi <= 1'b0;
    trig <= 3'h0;
    rd(2, dmachr_pkg::OFF_CTL, d, r);
    chk("abort flag", d & 32'h2, 32'h2);
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    end_sim;
  end
endmodule
`default_nettype wire
